// >>> rtl/gmc_mode_ctrl.sv
// mode control: maps two contact inputs and a metadata input to audio functions
// assumes contact pins are asynchronous, active low, and metadata state comes
// from a decoder on core_clk; software on Avalon-MM with waitrequest
// Behaviour
// [RL1] each contact input's function is active while its pin is low, the metadata input's while its state is active.
// [RL2] no function family may be given to more than one of the three inputs; such a write is refused.
// [RL3] while contact control is enabled only the inputs act and all other setting writes are blocked.
// [RL4] front upmix off/on engages upmixing while active, on/off upmixes by default and stops while active.
// [RL5] auto upmix sums upmixer with the remaining channels, auto/on gives full upmix with no feed-through while active.
// [RL6] emergency mode mutes the main program and feeds the emergency input to the front pair, polarity selectable.
// [RL7] local functions apply the voiceover mix in mix state and full substitution in replace state.
// [RL8] the metadata input follows two-channel mode of program one when enabled, enabled by default.
// [RL9] on metadata loss the metadata input is forced to the failure state, default inactive.
// [RL10] four program configurations with fixed input-pair assignment are offered.
// [RL11] downmix to the 7/8 output takes effect only in the 5.1 plus stereo configuration.
// [RL12] emergency insertion replaces all audio of program 1, program 2 or all programs.
// [RL13] the sample clock source selects external reference or internal oscillator.
// [RL14] master bypass drives the relay that routes inputs straight to outputs.
// [RL15] test generator selects tone kind, level defaulting to -20 dBFS, and channel cycle defaulting to main program.
// [RL16] backlight goes off after the selected timeout and on at once when a control is pressed, default two hours.
// [RL17] contact inputs are synchronised and debounced so one closure makes one clean change.
//
// Added by the designer: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ns
`include "gmc_defines.svh"

module gmc_mode_ctrl #(
	parameter int DEB_CYC = `GMC_DEB_CYC,
	parameter longint SEC_CYC = `GMC_SEC_CYC
) (
	// clock and reset
	input  wire logic              core_clk,
	input  wire logic              sys_rst,
	// contact pins, active low
	input  wire logic              gpi_a_n,
	input  wire logic              gpi_b_n,
	// metadata decoder status
	input  wire logic              meta_valid,
	input  wire logic              meta_two_ch,
	// front panel control activity pulse
	input  wire logic              key_press,
	// avalon-mm slave
	input  wire logic [7:0]        avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [31:0]       avs_writedata,
	input  wire logic [3:0]        avs_byteenable,
	output logic [31:0]            avs_readdata,
	output logic                   avs_waitrequest,
	// controls to the audio path, backlight and interrupt
	output gmc_pkg::gmc_proc_t     proc_ctl,
	output gmc_pkg::gmc_tone_ctl_t tone_ctl,
	output logic                   backlight_on,
	output logic                   irq
);
	import gmc_pkg::*;

	localparam int NIN = 3;

	// function family of a code; equal families on two inputs are refused
	function automatic logic [2:0] fam(input logic [3:0] f);
		unique case (f)
			GMC_FN_UPMIX_OFFON, GMC_FN_UPMIX_ONOFF: fam = 3'h1;
			GMC_FN_AUTO_OFFAUT, GMC_FN_AUTO_AUTOFF, GMC_FN_AUTO_AUTON: fam = 3'h2;
			GMC_FN_EMG_OFFON, GMC_FN_EMG_ONOFF: fam = 3'h3;
			GMC_FN_LOC_OFFMIX, GMC_FN_LOC_OFFREP, GMC_FN_LOC_MIXREP: fam = 3'h4;
			default: fam = 3'h0;
		endcase
	endfunction

	function automatic logic legal(input logic [11:0] f);
		logic [2:0] a;
		logic [2:0] b;
		logic [2:0] c;
		a = fam(f[3:0]);
		b = fam(f[7:4]);
		c = fam(f[11:8]);
		legal = !((a != 3'h0 && (a == b || a == c)) || (b != 3'h0 && b == c));
	endfunction

	// registers
	logic [5:0]    ctrl_r;
	logic [11:0]   func_r;
	logic [3:0]    cfg_r;
	logic [15:0]   tone_r;
	logic [2:0]    lcd_r;
	logic [2:0]    irq_stat_r;
	logic [2:0]    irq_mask_r;
	logic          ack_r;
	logic [NIN-1:0] in_act;
	logic [NIN-1:0] in_act_d_r;
	logic          meta_fail_d_r;
	logic          refused;

	wire gpi_en = ctrl_r[`GMC_CTRL_GPI_EN];
	// writes land at the edge where the master sees waitrequest low, not one earlier
	wire wr_go  = avs_write && ack_r;
	wire rd_go  = avs_read && !ack_r;

	// contact pin synchronisers and debounce counters
	logic [1:0] sync_r [2];
	logic [1:0] stable_r;
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_deb
			logic [15:0] cnt_r;
			// raw pin level into the first flop; no gate ahead of the synchroniser
			wire pin_raw = (gi == 0) ? gpi_a_n : gpi_b_n;
			always_ff @(posedge core_clk) begin
				if (sys_rst) begin
					// open-contact level, so no closure is seen after reset
					sync_r[gi] <= 2'h3;
				end else begin
					sync_r[gi] <= {sync_r[gi][0], pin_raw}; // RL17
				end
			end
			always_ff @(posedge core_clk) begin
				if (sys_rst) begin
					cnt_r         <= 16'h0;
					stable_r[gi]  <= 1'b0;
				end else if ((!sync_r[gi][1]) == stable_r[gi]) begin
					cnt_r <= 16'h0;
				end else if (cnt_r == 16'(DEB_CYC - 1)) begin
					cnt_r        <= 16'h0;
					stable_r[gi] <= !sync_r[gi][1]; // RL17
				end else begin
					cnt_r <= cnt_r + 16'h1;
				end
			end
		end
	endgenerate

	// metadata-driven virtual input
	logic meta_in;
	always_comb begin
		if (!meta_valid) begin
			meta_in = ctrl_r[`GMC_CTRL_FAIL_ON]; // RL9
		end else begin
			meta_in = ctrl_r[`GMC_CTRL_TWO_CH] && meta_two_ch; // RL8
		end
	end

	// inputs act only while contact control is enabled
	assign in_act = gpi_en ? {meta_in, stable_r} : 3'h0; // RL1

	// function resolution across the three inputs
	gmc_proc_t nxt;
	always_comb begin
		logic [3:0] f;
		logic emg_fn;
		f      = 4'h0;
		emg_fn = 1'b0;
		nxt              = '0;
		nxt.pgm_cfg      = gmc_pgm_t'(cfg_r[1:0]); // RL10
		nxt.emg_dst      = gmc_dst_t'(cfg_r[3:2]); // RL12
		nxt.bypass_relay = ctrl_r[`GMC_CTRL_BYPASS]; // RL14
		nxt.clk_ext      = ctrl_r[`GMC_CTRL_CLKSRC]; // RL13
		nxt.dmx_to_78    = ctrl_r[`GMC_CTRL_DMX] && cfg_r[1:0] == GMC_PGM_51_2_EMG; // RL11
		nxt.local_state  = GMC_LOC_OFF;
		for (int i = 0; i < NIN; i++) begin
			f = func_r[4*i +: 4];
			unique case (f)
				GMC_FN_UPMIX_OFFON: nxt.upmix_front = in_act[i]; // RL4
				GMC_FN_UPMIX_ONOFF: nxt.upmix_front = !in_act[i]; // RL4
				GMC_FN_AUTO_OFFAUT: nxt.auto_upmix = in_act[i]; // RL5
				GMC_FN_AUTO_AUTOFF: nxt.auto_upmix = !in_act[i]; // RL5
				GMC_FN_AUTO_AUTON: begin
					nxt.auto_upmix = !in_act[i]; // RL5
					nxt.full_upmix = in_act[i];
				end
				GMC_FN_EMG_OFFON: emg_fn = in_act[i]; // RL6
				GMC_FN_EMG_ONOFF: emg_fn = !in_act[i]; // RL6
				GMC_FN_LOC_OFFMIX: nxt.local_state = in_act[i] ? GMC_LOC_MIX : GMC_LOC_OFF; // RL7
				GMC_FN_LOC_OFFREP: nxt.local_state = in_act[i] ? GMC_LOC_REPLACE : GMC_LOC_OFF; // RL7
				GMC_FN_LOC_MIXREP: nxt.local_state = in_act[i] ? GMC_LOC_REPLACE : GMC_LOC_MIX; // RL7
				default: ;
			endcase
		end
		// emergency only exists where the 9/10 pair carries it
		nxt.emg_active = emg_fn && cfg_r[1:0] != GMC_PGM_51_2_LOC; // RL6
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			proc_ctl <= '0;
		end else begin
			proc_ctl <= nxt;
		end
	end

	// settings writes; only the enable is writable while contact control runs
	wire wr_blk = gpi_en; // RL3
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			ctrl_r <= `GMC_CTRL_RST;
			func_r <= `GMC_FUNC_RST;
			cfg_r  <= `GMC_CFG_RST;
			tone_r <= `GMC_TONE_RST;
			lcd_r  <= `GMC_LCD_RST;
		end else if (wr_go && avs_byteenable[0]) begin
			unique case (avs_address)
				`GMC_OFF_CTRL: begin
					if (wr_blk) begin
						ctrl_r[`GMC_CTRL_GPI_EN] <= avs_writedata[`GMC_CTRL_GPI_EN]; // RL3
					end else begin
						ctrl_r <= avs_writedata[5:0];
					end
				end
				`GMC_OFF_FUNC: begin
					if (!wr_blk && legal(avs_writedata[11:0])) begin
						func_r <= avs_writedata[11:0]; // RL2
					end
				end
				`GMC_OFF_CFG: if (!wr_blk && avs_writedata[3:2] != 2'h3) cfg_r <= avs_writedata[3:0];
				`GMC_OFF_TONE: if (!wr_blk) tone_r <= avs_writedata[15:0]; // RL15
				`GMC_OFF_LCD: if (!wr_blk) lcd_r <= avs_writedata[2:0]; // RL16
				default: ;
			endcase
		end
	end

	assign refused = wr_go && avs_byteenable[0] && (
		(wr_blk && avs_address != `GMC_OFF_CTRL && avs_address <= `GMC_OFF_LCD) ||
		(!wr_blk && avs_address == `GMC_OFF_FUNC && !legal(avs_writedata[11:0])));

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			tone_ctl <= '0;
		end else begin
			tone_ctl.on       <= tone_r[15]; // RL15
			tone_ctl.kind     <= (tone_r[14:12] > 3'h4) ? GMC_TONE_SINE : gmc_tone_t'(tone_r[14:12]);
			tone_ctl.cycle    <= tone_r[11:10];
			tone_ctl.chan     <= tone_r[9:6];
			tone_ctl.atten_db <= tone_r[5:0];
		end
	end

	// backlight timer: code 0 never, 1..7 = 1,5,15,120,60,240,480 minutes
	function automatic logic [31:0] to_sec(input logic [2:0] c);
		unique case (c)
			3'h0: to_sec = 32'h0;
			3'h1: to_sec = 32'd60;
			3'h2: to_sec = 32'd300;
			3'h3: to_sec = 32'd900;
			3'h4: to_sec = 32'd7200;
			3'h5: to_sec = 32'd3600;
			3'h6: to_sec = 32'd14400;
			default: to_sec = 32'd28800;
		endcase
	endfunction

	logic [31:0] tick_r;
	logic [31:0] secs_r;
	wire sec_tick = tick_r == 32'(SEC_CYC - 1);
	always_ff @(posedge core_clk) begin
		if (sys_rst || key_press || sec_tick) begin
			tick_r <= 32'h0;
		end else begin
			tick_r <= tick_r + 32'h1;
		end
	end
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			secs_r       <= 32'h0;
			backlight_on <= 1'b1;
		end else if (key_press) begin
			secs_r       <= 32'h0;
			backlight_on <= 1'b1; // RL16
		end else if (sec_tick && backlight_on && to_sec(lcd_r) != 32'h0) begin
			secs_r <= secs_r + 32'h1;
			if (secs_r + 32'h1 >= to_sec(lcd_r)) begin
				backlight_on <= 1'b0; // RL16
			end
		end
	end

	// interrupts: set wins over write-one-to-clear
	logic [2:0] ev;
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			in_act_d_r    <= 3'h0;
			meta_fail_d_r <= 1'b0;
		end else begin
			in_act_d_r    <= in_act;
			meta_fail_d_r <= !meta_valid;
		end
	end
	assign ev = {refused, !meta_valid && !meta_fail_d_r, in_act != in_act_d_r};
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			irq_stat_r <= 3'h0;
			irq_mask_r <= 3'h0;
		end else begin
			if (wr_go && avs_byteenable[0] && avs_address == `GMC_OFF_IRQ_MASK) begin
				irq_mask_r <= avs_writedata[2:0];
			end
			if (wr_go && avs_byteenable[0] && avs_address == `GMC_OFF_IRQ_STAT) begin
				irq_stat_r <= (irq_stat_r & ~avs_writedata[2:0]) | ev;
			end else begin
				irq_stat_r <= irq_stat_r | ev;
			end
		end
	end
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_stat_r & irq_mask_r);
		end
	end

	// bus answer: one wait cycle, then ack with read data
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			ack_r           <= 1'b0;
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0;
		end else begin
			ack_r <= (avs_read || avs_write) && !ack_r;
			avs_waitrequest <= !((avs_read || avs_write) && !ack_r);
			if (rd_go) begin
				unique case (avs_address)
					`GMC_OFF_CTRL:     avs_readdata <= {26'h0, ctrl_r};
					`GMC_OFF_FUNC:     avs_readdata <= {20'h0, func_r};
					`GMC_OFF_CFG:      avs_readdata <= {28'h0, cfg_r};
					`GMC_OFF_TONE:     avs_readdata <= {16'h0, tone_r};
					`GMC_OFF_LCD:      avs_readdata <= {29'h0, lcd_r};
					`GMC_OFF_STATE:    avs_readdata <= {24'h0, backlight_on, meta_valid,
						proc_ctl.local_state, proc_ctl.emg_active, proc_ctl.full_upmix,
						proc_ctl.auto_upmix, proc_ctl.upmix_front};
					`GMC_OFF_IRQ_STAT: avs_readdata <= {29'h0, irq_stat_r};
					`GMC_OFF_IRQ_MASK: avs_readdata <= {29'h0, irq_mask_r};
					default:           avs_readdata <= 32'h0;
				endcase
			end
		end
	end
	// checks
	chk_refused_flag: assert property (@(posedge core_clk) disable iff (sys_rst) // RL2
		refused |=> irq_stat_r[`GMC_IRQ_REFUSED]) else $error("refused write not flagged");
	chk_func_legal: assert property (@(posedge core_clk) disable iff (sys_rst) // RL2
		legal(func_r)) else $error("duplicate function family held");
	chk_blocked_cfg: assert property (@(posedge core_clk) disable iff (sys_rst) // RL3
		gpi_en |=> $stable(func_r) && $stable(cfg_r)) else $error("setting changed under gpi");
	chk_dmx_only_51: assert property (@(posedge core_clk) disable iff (sys_rst) // RL11
		proc_ctl.dmx_to_78 |-> proc_ctl.pgm_cfg == GMC_PGM_51_2_EMG) else $error("downmix wrong cfg");
	chk_meta_fail: assert property (@(posedge core_clk) disable iff (sys_rst) // RL9
		!meta_valid && gpi_en |-> meta_in == ctrl_r[`GMC_CTRL_FAIL_ON]) else $error("fail state");
	chk_upmix_pol: assert property (@(posedge core_clk) disable iff (sys_rst) // RL4
		gpi_en && $stable(gpi_en) && func_r[3:0] == GMC_FN_UPMIX_OFFON && $stable(func_r)
		|=> proc_ctl.upmix_front == $past(in_act[0])) else $error("upmix polarity");
	chk_debounce: assert property (@(posedge core_clk) disable iff (sys_rst) // RL17
		$changed(stable_r[0]) |-> $past(sync_r[0][1]) != stable_r[0]) else $error("debounce");
	chk_backlight_key: assert property (@(posedge core_clk) disable iff (sys_rst) // RL16
		key_press |=> backlight_on) else $error("backlight not restored");
	chk_bypass_out: assert property (@(posedge core_clk) disable iff (sys_rst) // RL14
		##1 proc_ctl.bypass_relay == $past(ctrl_r[`GMC_CTRL_BYPASS])) else $error("bypass");
	// gating, flags, interrupt line, blocking and backlight hold
	chk_emg_cfg_gate: assert property (@(posedge core_clk) disable iff (sys_rst) // RL6
		proc_ctl.emg_active |-> proc_ctl.pgm_cfg != GMC_PGM_51_2_LOC) else $error("emergency cfg");
	chk_act_flag: assert property (@(posedge core_clk) disable iff (sys_rst) // RL1
		ev[`GMC_IRQ_ACT] |=> irq_stat_r[`GMC_IRQ_ACT]) else $error("input change not flagged");
	chk_meta_flag: assert property (@(posedge core_clk) disable iff (sys_rst) // RL9
		ev[`GMC_IRQ_META_FAIL] |=> irq_stat_r[`GMC_IRQ_META_FAIL]) else $error("meta loss not flagged");
	chk_irq_raise: assert property (@(posedge core_clk) disable iff (sys_rst) // RL3
		(|(irq_stat_r & irq_mask_r)) |=> irq) else $error("irq not raised");
	chk_irq_drop: assert property (@(posedge core_clk) disable iff (sys_rst) // RL3
		(!(|(irq_stat_r & irq_mask_r))) |=> !irq) else $error("irq not dropped");
	chk_blocked_misc: assert property (@(posedge core_clk) disable iff (sys_rst) // RL3
		gpi_en |=> $stable(tone_r) && $stable(lcd_r)) else $error("tone or lcd changed under gpi");
	chk_relay_held: assert property (@(posedge core_clk) disable iff (sys_rst) // RL3
		gpi_en |=> $stable(ctrl_r[`GMC_CTRL_BYPASS])) else $error("bypass changed under gpi");
	chk_backlight_never: assert property (@(posedge core_clk) disable iff (sys_rst) // RL16
		lcd_r == 3'h0 && backlight_on |=> backlight_on) else $error("backlight dropped");
endmodule

// >>> rtl/gmc_defines.svh
// constants of the input-to-function mode control block
// assumes inclusion by bare name; definitions only
`ifndef GMC_DEFINES_SVH
`define GMC_DEFINES_SVH

// register byte offsets
`define GMC_OFF_CTRL      8'h00
`define GMC_OFF_FUNC      8'h04
`define GMC_OFF_CFG       8'h08
`define GMC_OFF_TONE      8'h0c
`define GMC_OFF_LCD       8'h10
`define GMC_OFF_STATE     8'h14
`define GMC_OFF_IRQ_STAT  8'h18
`define GMC_OFF_IRQ_MASK  8'h1c

// ctrl field positions
`define GMC_CTRL_GPI_EN   0
`define GMC_CTRL_BYPASS   1
`define GMC_CTRL_CLKSRC   2
`define GMC_CTRL_TWO_CH   3
`define GMC_CTRL_FAIL_ON  4
`define GMC_CTRL_DMX      5

// reset values
`define GMC_CTRL_RST      6'h08
`define GMC_FUNC_RST      12'h000
`define GMC_CFG_RST       4'h0
`define GMC_TONE_RST      16'h0014
`define GMC_LCD_RST       3'h4

// timing: debounce, in microseconds
`define GMC_DEB_US        5
`define GMC_CLK_MHZ       125
`define GMC_DEB_CYC       (`GMC_DEB_US * `GMC_CLK_MHZ)

// backlight timer: core_clk cycles in one second
`define GMC_SEC_CYC       125000000

// interrupt bit positions
`define GMC_IRQ_ACT       0
`define GMC_IRQ_META_FAIL 1
`define GMC_IRQ_REFUSED   2

`endif

// >>> rtl/gmc_pkg.sv
// types of the input-to-function mode control block
package gmc_pkg;
	typedef enum logic [3:0] {
		GMC_FN_DISABLE     = 4'h0,
		GMC_FN_UPMIX_OFFON = 4'h1,
		GMC_FN_UPMIX_ONOFF = 4'h2,
		GMC_FN_AUTO_OFFAUT = 4'h3,
		GMC_FN_AUTO_AUTOFF = 4'h4,
		GMC_FN_AUTO_AUTON  = 4'h5,
		GMC_FN_EMG_OFFON   = 4'h6,
		GMC_FN_EMG_ONOFF   = 4'h7,
		GMC_FN_LOC_OFFMIX  = 4'h8,
		GMC_FN_LOC_OFFREP  = 4'h9,
		GMC_FN_LOC_MIXREP  = 4'ha
	} gmc_func_t;

	typedef enum logic [1:0] {
		GMC_PGM_51_2_EMG   = 2'h0,
		GMC_PGM_51_LOC_EMG = 2'h1,
		GMC_PGM_51_2_LOC   = 2'h2,
		GMC_PGM_4X2        = 2'h3
	} gmc_pgm_t;

	typedef enum logic [1:0] {
		GMC_DST_PGM1 = 2'h0,
		GMC_DST_PGM2 = 2'h1,
		GMC_DST_ALL  = 2'h2
	} gmc_dst_t;

	typedef enum logic [1:0] {
		GMC_LOC_OFF     = 2'h0,
		GMC_LOC_MIX     = 2'h1,
		GMC_LOC_REPLACE = 2'h3
	} gmc_loc_t;

	typedef enum logic [2:0] {
		GMC_TONE_SINE  = 3'h0,
		GMC_TONE_VOICE = 3'h1,
		GMC_TONE_PINK  = 3'h2,
		GMC_TONE_WHITE = 3'h3,
		GMC_TONE_BROWN = 3'h4
	} gmc_tone_t;

	// processing controls presented to the audio path
	typedef struct packed {
		logic     upmix_front;
		logic     auto_upmix;
		logic     full_upmix;
		logic     emg_active;
		gmc_loc_t local_state;
		gmc_pgm_t pgm_cfg;
		logic     dmx_to_78;
		gmc_dst_t emg_dst;
		logic     bypass_relay;
		logic     clk_ext;
	} gmc_proc_t;

	// test generator controls
	typedef struct packed {
		logic      on;
		gmc_tone_t kind;
		logic [1:0] cycle;
		logic [3:0] chan;
		logic [5:0] atten_db;
	} gmc_tone_ctl_t;
endpackage

// >>> tb/gmc_far_end.sv
// far side of the mode control block: two contact closures and a metadata decoder
// assumes the bench commands closures and metadata state on core_clk edges
`timescale 1ns/1ns

module gmc_far_end (
	// clock
	input  wire logic       core_clk,
	// commands from the bench
	input  wire logic [1:0] close_cmd,
	input  wire logic       meta_ok,
	input  wire logic       meta_2ch,
	// pins and decoder status toward the block
	output logic            gpi_a_n,
	output logic            gpi_b_n,
	output logic            meta_valid,
	output logic            meta_two_ch
);
	logic [1:0] cmd_r;
	logic [1:0] pin_r;
	logic [2:0] bnc_r [2];
	initial begin
		cmd_r = 2'h0;
		pin_r = 2'h3;
		bnc_r = '{3'h0, 3'h0};
		meta_valid = 1'b0;
		meta_two_ch = 1'b0;
	end
	// a real contact chatters for a few cycles before it settles
	always @(posedge core_clk) begin
		cmd_r <= close_cmd;
		for (int i = 0; i < 2; i++) begin
			if (close_cmd[i] != cmd_r[i])
				bnc_r[i] <= 3'h5;
			else if (bnc_r[i] != 3'h0)
				bnc_r[i] <= bnc_r[i] - 3'h1;
			pin_r[i] <= (bnc_r[i] != 3'h0) ? ~pin_r[i] : ~close_cmd[i];
		end
	end
	assign gpi_a_n = pin_r[0];
	assign gpi_b_n = pin_r[1];
	// with no valid stream the decoded mode bit carries nothing: keep it moving
	always @(posedge core_clk) begin
		meta_valid <= meta_ok;
		meta_two_ch <= meta_ok ? meta_2ch : ~meta_two_ch;
	end
endmodule

// >>> tb/test_gmc_mode_ctrl.sv
// self-checking bench of the mode control block
// assumes the far-side model and the design; short debounce and second counts
`timescale 1ns/1ns
`include "gmc_defines.svh"

module test_gmc_mode_ctrl;
	import gmc_pkg::*;
	logic          core_clk, sys_rst, key_press, meta_ok, meta_2ch;
	logic [1:0]    close_cmd;
	logic          gpi_a_n, gpi_b_n, meta_valid, meta_two_ch;
	logic [7:0]    avs_address;
	logic          avs_read, avs_write;
	logic [31:0]   avs_writedata, avs_readdata, r;
	logic          avs_waitrequest, backlight_on, irq;
	gmc_proc_t     proc_ctl;
	gmc_tone_ctl_t tone_ctl;
	int            err_total, comparisons, cyc;
	logic [1:0]    p, d;
	logic [2:0]    x;
	logic [15:0]   t;

	gmc_mode_ctrl #(.DEB_CYC(4), .SEC_CYC(10)) dut_u (
		.core_clk(core_clk), .sys_rst(sys_rst), .gpi_a_n(gpi_a_n), .gpi_b_n(gpi_b_n),
		.meta_valid(meta_valid), .meta_two_ch(meta_two_ch), .key_press(key_press),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .proc_ctl(proc_ctl), .tone_ctl(tone_ctl),
		.backlight_on(backlight_on), .irq(irq));
	gmc_far_end far_u (.core_clk(core_clk), .close_cmd(close_cmd), .meta_ok(meta_ok),
		.meta_2ch(meta_2ch), .gpi_a_n(gpi_a_n), .gpi_b_n(gpi_b_n),
		.meta_valid(meta_valid), .meta_two_ch(meta_two_ch));

	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	task automatic test_done();
		if (err_total == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// the run should need well under this many cycles
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			test_done();
		end
	end

	task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
		comparisons++;
		if (s !== e) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic bus(logic we, logic [7:0] a, logic [31:0] wd, output logic [31:0] rdat);
		avs_address <= a;
		avs_writedata <= wd;
		avs_write <= we;
		avs_read <= !we;
		@(posedge core_clk);
		while (avs_waitrequest !== 1'b0) @(posedge core_clk);
		rdat = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge core_clk);
	endtask

	task automatic settle(int n);
		repeat (n) @(posedge core_clk);
	endtask

	function automatic logic [1:0] fn_exp(logic [3:0] c, logic a);
		case (c)
			4'h2, 4'h4, 4'h7: fn_exp = {1'b0, !a};
			4'h8: fn_exp = a ? 2'h1 : 2'h0;
			4'h9: fn_exp = a ? 2'h3 : 2'h0;
			4'ha: fn_exp = a ? 2'h3 : 2'h1;
			default: fn_exp = {1'b0, a};
		endcase
	endfunction

	function automatic logic [1:0] fn_obs(logic [3:0] c, gmc_proc_t q);
		case (c)
			4'h1, 4'h2: fn_obs = {1'b0, q.upmix_front};
			4'h3, 4'h4: fn_obs = {1'b0, q.auto_upmix};
			4'h5: fn_obs = {1'b0, q.full_upmix};
			4'h6, 4'h7: fn_obs = {1'b0, q.emg_active};
			default: fn_obs = q.local_state;
		endcase
	endfunction

	logic [7:0]  rst_a [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h20};
	logic [31:0] rst_v [6] = '{32'h8, 32'h0, 32'h0, 32'h14, 32'h4, 32'h0};

	initial begin
		sys_rst = 1'b1;
		key_press = 1'b0;
		meta_ok = 1'b1;
		meta_2ch = 1'b0;
		close_cmd = 2'h0;
		avs_address = 8'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		settle(2);
		sys_rst <= 1'b0;
		void'($urandom(39));
		for (int i = 0; i < 6; i++) begin
			bus(1'b0, rst_a[i], 32'h0, r);
			chk("reset value", rst_v[i], r);
		end
		chk("tone level", 32'd20, tone_ctl.atten_db);
		chk("tone cycle", 32'h0, tone_ctl.cycle);
		chk("backlight", 32'h1, backlight_on);
		// settings, every program and destination code first
		for (int k = 0; k < 16; k++) begin
			p = (k < 4) ? 2'(k) : 2'($urandom_range(3));
			d = (k < 3) ? 2'(k) : 2'($urandom_range(2));
			x = 3'($urandom_range(7));
			t = {1'($urandom), 3'($urandom_range(4)), 2'($urandom_range(2)), 10'($urandom)};
			bus(1'b1, `GMC_OFF_CFG, {28'h0, d, p}, r);
			bus(1'b1, `GMC_OFF_CTRL, {26'h0, x[2], 2'h1, x[1:0], 1'b0}, r);
			bus(1'b1, `GMC_OFF_TONE, {16'h0, t}, r);
			settle(3);
			chk("pgm_cfg", p, proc_ctl.pgm_cfg);
			chk("emg_dst", d, proc_ctl.emg_dst);
			chk("bypass", x[0], proc_ctl.bypass_relay);
			chk("clk_ext", x[1], proc_ctl.clk_ext);
			if (p != 2'h2)
				chk("dmx_to_78", x[2] && p == 2'h0, proc_ctl.dmx_to_78);
			chk("tone_ctl", t, tone_ctl);
		end
		// every function on every input, both states
		bus(1'b1, `GMC_OFF_CFG, 32'h1, r);
		bus(1'b1, `GMC_OFF_CTRL, 32'h8, r);
		for (int i = 0; i < 3; i++) begin
			for (int c = 1; c <= 10; c++) begin
				bus(1'b1, `GMC_OFF_CTRL, 32'h8, r);
				bus(1'b1, `GMC_OFF_FUNC, 32'(c) << (4 * i), r);
				bus(1'b1, `GMC_OFF_CTRL, 32'h9, r);
				for (int a = 0; a < 3; a++) begin
					close_cmd <= (i < 2 && a == 1) ? 2'(1 << i) : 2'h0;
					meta_2ch <= (i == 2 && a == 1);
					settle(20);
					chk("function", fn_exp(4'(c), a == 1), fn_obs(4'(c), proc_ctl));
				end
			end
		end
		// metadata input: loss, failure state, two-channel detection off
		meta_2ch <= 1'b1;
		meta_ok <= 1'b0;
		settle(8);
		chk("meta fail off", 32'h1, proc_ctl.local_state);
		bus(1'b1, `GMC_OFF_CTRL, 32'h8, r);
		bus(1'b1, `GMC_OFF_CTRL, 32'h18, r);
		bus(1'b1, `GMC_OFF_CTRL, 32'h19, r);
		settle(8);
		chk("meta fail on", 32'h3, proc_ctl.local_state);
		meta_ok <= 1'b1;
		bus(1'b1, `GMC_OFF_CTRL, 32'h8, r);
		bus(1'b1, `GMC_OFF_CTRL, 32'h1, r);
		settle(8);
		chk("two ch off", 32'h1, proc_ctl.local_state);
		bus(1'b0, `GMC_OFF_STATE, 32'h0, r);
		chk("state", 32'hd0, r);
		// settings blocked while contact control is on, refusal interrupt
		bus(1'b1, `GMC_OFF_IRQ_STAT, 32'h7, r);
		bus(1'b1, `GMC_OFF_IRQ_MASK, 32'h4, r);
		chk("irq idle", 32'h0, irq);
		bus(1'b1, `GMC_OFF_CFG, 32'h3, r);
		bus(1'b1, `GMC_OFF_CTRL, 32'h0b, r);
		settle(3);
		chk("irq refused", 32'h1, irq);
		bus(1'b0, `GMC_OFF_CFG, 32'h0, r);
		chk("cfg blocked", 32'h1, r);
		bus(1'b0, `GMC_OFF_CTRL, 32'h0, r);
		chk("ctrl blocked", 32'h1, r);
		chk("bypass blocked", 32'h0, proc_ctl.bypass_relay);
		bus(1'b1, `GMC_OFF_IRQ_STAT, 32'h4, r);
		settle(3);
		chk("irq cleared", 32'h0, irq);
		// duplicate family refused, even with contact control off
		bus(1'b1, `GMC_OFF_CTRL, 32'h8, r);
		bus(1'b1, `GMC_OFF_FUNC, 32'h21, r);
		bus(1'b1, `GMC_OFF_FUNC, 32'h76, r);
		bus(1'b0, `GMC_OFF_FUNC, 32'h0, r);
		chk("func dup", 32'ha00, r);
		chk("irq dup", 32'h1, irq);
		bus(1'b1, `GMC_OFF_IRQ_MASK, 32'h0, r);
		// backlight: code 1 is 60 s, 600 cycles here
		bus(1'b1, `GMC_OFF_LCD, 32'h1, r);
		key_press <= 1'b1;
		@(posedge core_clk);
		key_press <= 1'b0;
		settle(550);
		chk("backlight held", 32'h1, backlight_on);
		settle(70);
		chk("backlight off", 32'h0, backlight_on);
		key_press <= 1'b1;
		@(posedge core_clk);
		key_press <= 1'b0;
		settle(3);
		chk("backlight wake", 32'h1, backlight_on);
		test_done();
	end
endmodule
